/* File: phy_autoneg_gigabit_regs.sv */
// Negotiation advertisement, partner, next-page and gigabit register set
`timescale 1ns/10ps
module phy_autoneg_gigabit_regs
	import phy_an_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [3:0] sel_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic rx_base_valid,
	input wire logic [15:0] rx_base_word,
	input wire logic rx_next_valid,
	input wire logic [15:0] rx_next_word,
	input wire logic partner_an_able,
	input wire logic parallel_fault,
	input wire logic next_page_sent,
	input wire logic tx_ack2,
	input wire logic ms_config_fault,
	input wire logic ms_resolved_master,
	input wire logic local_rx_ok,
	input wire logic remote_rx_ok,
	input wire logic partner_1000_full,
	input wire logic partner_1000_half,
	input wire logic [7:0] idle_error_msb,
	output logic [15:0] tx_base_word,
	output logic [15:0] tx_next_word,
	output logic [2:0] test_mode,
	output logic ms_manual,
	output logic ms_master_value,
	output logic port_multi,
	output logic adv_1000_full,
	output logic adv_1000_half
);

	// ------------------------------------------------------------
	// Bus front end
	// ------------------------------------------------------------
	reg_access_if bus ();

	wb_reg_slave u_slave (
		.clk(clk),
		.resetn(resetn),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.we_i(we_i),
		.adr_i(adr_i),
		.dat_i(dat_i),
		.sel_i(sel_i),
		.dat_o(dat_o),
		.ack_o(ack_o),
		.bus(bus)
	);

	// Byte-lane merge limited to the writable bits of a register
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] wd, input logic [1:0] be, input logic [15:0] msk);
		logic [15:0] lane;
		lane = {{8{be[1]}}, {8{be[0]}}} & msk;
		merge = (old & ~lane) | (wd & lane);
	endfunction : merge

	function automatic logic hit_wr(input logic [3:0] want);
		hit_wr = bus.wr && (bus.idx == want);
	endfunction : hit_wr

	function automatic logic hit_rd(input logic [3:0] want);
		hit_rd = bus.rd && (bus.idx == want);
	endfunction : hit_rd

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [15:0] adv_r;
	logic [15:0] partner_r;
	logic pd_fault_r;
	logic page_rx_r;
	logic lp_an_r;
	logic [15:0] np_tx_r;
	logic toggle_r;
	logic ack2_r;
	logic [15:0] np_rx_r;
	logic [15:0] gb_ctrl_r;
	logic [15:0] gb_status_r;
	logic [15:0] exp_word;
	logic [15:0] np_tx_word;

	// ------------------------------------------------------------
	// Advertisement register
	// ------------------------------------------------------------
	// advertisement index
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			adv_r <= ADV_RESET;
		end else if (hit_wr(IDX_ADVERTISE)) begin
			adv_r <= merge(adv_r, bus.wdata, bus.be, ADV_WR_MASK);
		end
	end

	// ------------------------------------------------------------
	// Partner pages and expansion flags
	// ------------------------------------------------------------
	// base word capture
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			partner_r <= 16'h0;
		end else if (rx_base_valid) begin
			partner_r <= rx_base_word;
		end
	end

	// next page capture, bit 15 reserved
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			np_rx_r <= 16'h0;
		end else if (rx_next_valid) begin
			np_rx_r <= {1'b0, rx_next_word[14:0]};
		end
	end

	// fault latched until read
	// A fresh event in the read cycle survives the clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pd_fault_r <= 1'b0;
		end else if (parallel_fault) begin
			pd_fault_r <= 1'b1;
		end else if (hit_rd(IDX_EXPANSION)) begin
			pd_fault_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			page_rx_r <= 1'b0;
		end else if (rx_base_valid || rx_next_valid) begin
			page_rx_r <= 1'b1;
		end else if (hit_rd(IDX_EXPANSION)) begin
			page_rx_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lp_an_r <= 1'b0;
		end else begin
			lp_an_r <= partner_an_able;
		end
	end

	// partner next page from base word
	always_comb begin
		exp_word = 16'h0;
		exp_word[EXP_PD_FAULT] = pd_fault_r;
		exp_word[EXP_LP_NP] = partner_r[CW_NEXT_PAGE];
		exp_word[EXP_LOCAL_NP] = 1'b1;
		exp_word[EXP_PAGE_RX] = page_rx_r;
		exp_word[EXP_LP_AN] = lp_an_r;
	end

	// ------------------------------------------------------------
	// Next page transmit
	// ------------------------------------------------------------
	// writable fields only
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			np_tx_r <= NP_TX_RESET;
		end else if (hit_wr(IDX_NP_TX)) begin
			np_tx_r <= merge(np_tx_r, bus.wdata, bus.be, NP_TX_WR_MASK);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			toggle_r <= 1'b0;
		end else if (next_page_sent) begin
			toggle_r <= !toggle_r;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack2_r <= 1'b0;
		end else begin
			ack2_r <= tx_ack2;
		end
	end

	always_comb begin
		np_tx_word = np_tx_r;
		np_tx_word[NP_ACK2] = ack2_r;
		np_tx_word[NP_TOGGLE] = toggle_r;
	end

	// ------------------------------------------------------------
	// Gigabit control and status
	// ------------------------------------------------------------
	// test mode field
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gb_ctrl_r <= GB_CTRL_RESET;
		end else if (hit_wr(IDX_GB_CTRL)) begin
			gb_ctrl_r <= merge(gb_ctrl_r, bus.wdata, bus.be, 16'hffff);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gb_status_r <= 16'h0;
		end else begin
			gb_status_r <= {ms_config_fault, ms_resolved_master, local_rx_ok,
				remote_rx_ok, partner_1000_full, partner_1000_half, 2'b00,
				idle_error_msb};
		end
	end

	// ------------------------------------------------------------
	// Read multiplexer
	// ------------------------------------------------------------
	// unlisted indices miss
	always_comb begin
		bus.hit = 1'b1;
		case (bus.idx)
			IDX_ADVERTISE: bus.rdata = adv_r;
			IDX_PARTNER: bus.rdata = partner_r;
			IDX_EXPANSION: bus.rdata = exp_word;
			IDX_NP_TX: bus.rdata = np_tx_word;
			IDX_NP_RX: bus.rdata = np_rx_r;
			IDX_GB_CTRL: bus.rdata = gb_ctrl_r;
			IDX_GB_STATUS: bus.rdata = gb_status_r;
			IDX_GB_EXT: bus.rdata = GB_EXT_VALUE;
			default: begin
				bus.rdata = 16'h0;
				bus.hit = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Outputs toward the negotiation engine
	// ------------------------------------------------------------
	// Registered copies cost a cycle of latency but keep outputs clean
	// remote fault into code word
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_base_word <= ADV_RESET;
			tx_next_word <= NP_TX_RESET;
		end else begin
			tx_base_word <= adv_r;
			tx_next_word <= np_tx_word;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			test_mode <= TEST_NORMAL;
			ms_manual <= 1'b0;
			ms_master_value <= 1'b0;
			port_multi <= 1'b0;
			adv_1000_full <= 1'b0;
			adv_1000_half <= 1'b0;
		end else begin
			// reserved codes fall back to normal
			test_mode <= (gb_ctrl_r[15:13] > TEST_LAST) ? TEST_NORMAL
				: gb_ctrl_r[15:13];
			ms_manual <= gb_ctrl_r[12];
			ms_master_value <= gb_ctrl_r[11];
			port_multi <= gb_ctrl_r[10];
			adv_1000_full <= gb_ctrl_r[9];
			adv_1000_half <= gb_ctrl_r[8];
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	a_remote_fault_out: assert property (
		bus.wr && bus.idx == IDX_ADVERTISE && bus.be[1] |=> ##1
			tx_base_word[ADV_REMOTE_FAULT] == $past(bus.wdata[13], 2))
		else $error("remote fault not carried to code word");

	a_pause_write: assert property (
		bus.wr && bus.idx == IDX_ADVERTISE && bus.be[1] |=>
			adv_r[ADV_ASYM_PAUSE:ADV_PAUSE] == $past(bus.wdata[11:10]))
		else $error("pause bits not written");

	a_t4_zero: assert property (
		bus.rd && bus.idx == IDX_ADVERTISE |-> bus.rdata[ADV_T4] == 1'b0)
		else $error("T4 bit reads one");

	a_selector_fixed: assert property (
		bus.wr && bus.idx == IDX_ADVERTISE |=> adv_r[4:0] == ADV_SELECTOR)
		else $error("selector field changed");

	a_partner_copy: assert property (
		rx_base_valid |=> partner_r == $past(rx_base_word))
		else $error("partner word not captured");

	a_page_received: assert property (
		rx_base_valid || rx_next_valid |=> page_rx_r ##1
			(page_rx_r || $past(bus.rd && bus.idx == IDX_EXPANSION)))
		else $error("page received lost");

	a_toggle_flip: assert property (
		next_page_sent |=> ##1 tx_next_word[NP_TOGGLE] != $past(toggle_r, 2))
		else $error("toggle did not flip");

	a_ext_status: assert property (
		bus.rd && bus.idx == IDX_GB_EXT |=>
			dat_o == {16'h0, GB_EXT_VALUE} && ack_o)
		else $error("extended status wrong");

	a_gb_reserved: assert property (
		bus.rd && bus.idx == IDX_GB_STATUS |=> dat_o[9:8] == 2'b00)
		else $error("reserved status bits set");

endmodule : phy_autoneg_gigabit_regs

/* File: phy_an_pkg.sv */
// Register map, field layout and reset values of the negotiation register set
package phy_an_pkg;

	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [3:0] IDX_ADVERTISE = 4'h4;
	localparam logic [3:0] IDX_PARTNER = 4'h5;
	localparam logic [3:0] IDX_EXPANSION = 4'h6;
	localparam logic [3:0] IDX_NP_TX = 4'h7;
	localparam logic [3:0] IDX_NP_RX = 4'h8;
	localparam logic [3:0] IDX_GB_CTRL = 4'h9;
	localparam logic [3:0] IDX_GB_STATUS = 4'ha;
	localparam logic [3:0] IDX_GB_EXT = 4'hf;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int ADV_MORE_PAGES = 15;
	localparam int ADV_REMOTE_FAULT = 13;
	localparam int ADV_ASYM_PAUSE = 11;
	localparam int ADV_PAUSE = 10;
	localparam int ADV_T4 = 9;
	localparam int EXP_PD_FAULT = 4;
	localparam int EXP_LP_NP = 3;
	localparam int EXP_LOCAL_NP = 2;
	localparam int EXP_PAGE_RX = 1;
	localparam int EXP_LP_AN = 0;
	localparam int NP_ACK2 = 12;
	localparam int NP_TOGGLE = 11;
	localparam int CW_NEXT_PAGE = 15;

	// ------------------------------------------------------------
	// Reset and fixed values
	// ------------------------------------------------------------
	localparam logic [15:0] ADV_RESET = 16'h01e1;
	localparam logic [15:0] ADV_WR_MASK = 16'hbde0;
	localparam logic [4:0] ADV_SELECTOR = 5'h01;
	localparam logic [15:0] NP_TX_RESET = 16'h2001;
	localparam logic [15:0] NP_TX_WR_MASK = 16'ha7ff;
	localparam logic [15:0] GB_CTRL_RESET = 16'h0000;
	localparam logic [15:0] GB_EXT_VALUE = 16'h3000;
	localparam logic [2:0] TEST_NORMAL = 3'h0;
	localparam logic [2:0] TEST_LAST = 3'h4;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ACK = 2'b01
	} bus_state_e;

endpackage : phy_an_pkg

/* File: reg_access_if.sv */
// Register access strobes between the bus slave and the register set
`timescale 1ns/10ps
interface reg_access_if;
	logic wr;
	logic rd;
	logic [3:0] idx;
	logic [15:0] wdata;
	logic [1:0] be;
	logic [15:0] rdata;
	logic hit;
	modport slave (output wr, rd, idx, wdata, be, input rdata, hit);
	modport regs (input wr, rd, idx, wdata, be, output rdata, hit);
endinterface : reg_access_if

/* File: wb_reg_slave.sv */
// Classic Wishbone slave front end with a registered one-wait answer
`timescale 1ns/10ps
module wb_reg_slave
	import phy_an_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [3:0] sel_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	reg_access_if.slave bus
);

	// ------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------
	bus_state_e state_r;
	logic req;

	// Any access in the low 64 bytes maps, whatever adr_i[1:0] and sel_i; the rest answer zero
	assign req = cyc_i && stb_i && (state_r == BUS_IDLE);
	assign bus.idx = adr_i[5:2];
	assign bus.wdata = dat_i[15:0];
	assign bus.be = sel_i[1:0];
	assign bus.wr = req && we_i && (adr_i[31:6] == 26'h0);
	assign bus.rd = req && !we_i && (adr_i[31:6] == 26'h0);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= BUS_IDLE;
		end else begin
			case (state_r)
				BUS_IDLE: begin
					if (req) begin
						state_r <= BUS_ACK;
					end
				end
				BUS_ACK: state_r <= BUS_IDLE;
				default: state_r <= BUS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else begin
			ack_o <= req;
			if (req) begin
				dat_o <= (bus.rd && bus.hit) ? {16'h0, bus.rdata} : 32'h0;
			end
		end
	end

endmodule : wb_reg_slave

/* File: link_partner_model.sv */
// Link partner model: received pages, events and line status
`timescale 1ns/10ps
module link_partner_model (
	input wire logic clk,
	output logic rx_base_valid,
	output logic [15:0] rx_base_word,
	output logic rx_next_valid,
	output logic [15:0] rx_next_word,
	output logic partner_an_able,
	output logic parallel_fault,
	output logic next_page_sent,
	output logic [14:0] st
);
	// ------------------------------------------------------------
	// Idle levels
	// ------------------------------------------------------------
	initial begin
		{rx_base_valid, rx_next_valid, parallel_fault} = 3'h0;
		{rx_base_word, rx_next_word, st} = 47'h0;
		{partner_an_able, next_page_sent} = 2'h0;
	end
	// ------------------------------------------------------------
	// Page delivery
	// ------------------------------------------------------------
	// Word flips after the strobe so a late capture reads garbage
	task automatic base(input logic [15:0] w, input logic able);
		@(posedge clk);
		rx_base_valid <= 1'b1;
		rx_base_word <= w;
		partner_an_able <= able;
		@(posedge clk);
		rx_base_valid <= 1'b0;
		rx_base_word <= ~w;
	endtask : base
	task automatic next(input logic [15:0] w);
		@(posedge clk);
		rx_next_valid <= 1'b1;
		rx_next_word <= w;
		@(posedge clk);
		rx_next_valid <= 1'b0;
		rx_next_word <= ~w;
	endtask : next
	// One-cycle event pulses, no kinder than the line
	task automatic ev(input logic f, input logic s);
		@(posedge clk);
		parallel_fault <= f;
		next_page_sent <= s;
		@(posedge clk);
		parallel_fault <= 1'b0;
		next_page_sent <= 1'b0;
	endtask : ev
	task automatic status(input logic [14:0] v);
		@(posedge clk);
		st <= v;
	endtask : status
endmodule : link_partner_model

/* File: phy_autoneg_gigabit_regs_tb_top.sv */
// Self-checking bench for the negotiation register set
`timescale 1ns/10ps
module phy_autoneg_gigabit_regs_tb_top;
	import phy_an_pkg::*;
	typedef struct packed {logic chk; logic [31:0] v;} exp_s;
	logic clk, resetn, cyc_i, stb_i, we_i, ack_o;
	logic [31:0] adr_i, dat_i, dat_o, seed, r;
	logic [3:0] sel_i;
	logic rx_base_valid, rx_next_valid, partner_an_able;
	logic parallel_fault, next_page_sent;
	logic [15:0] rx_base_word, rx_next_word, tx_base_word, tx_next_word;
	logic [15:0] v, w;
	logic [14:0] st;
	logic [2:0] test_mode;
	logic ms_manual, ms_master_value, port_multi;
	logic adv_1000_full, adv_1000_half;
	logic [7:0] ra [10] = '{8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24,
		8'h28, 8'h3c, 8'h2c, 8'h00};
	logic [15:0] rv [10] = '{16'h01e1, 16'h0, 16'h0004, 16'h2001, 16'h0,
		16'h0, 16'h0, 16'h3000, 16'h0, 16'h0};
	exp_s q[$];
	exp_s x;
	int errors, checks;
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	phy_autoneg_gigabit_regs i_dut (.clk(clk), .resetn(resetn),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
		.rx_base_valid(rx_base_valid), .rx_base_word(rx_base_word),
		.rx_next_valid(rx_next_valid), .rx_next_word(rx_next_word),
		.partner_an_able(partner_an_able), .parallel_fault(parallel_fault),
		.next_page_sent(next_page_sent), .tx_ack2(st[14]),
		.ms_config_fault(st[13]), .ms_resolved_master(st[12]),
		.local_rx_ok(st[11]), .remote_rx_ok(st[10]),
		.partner_1000_full(st[9]), .partner_1000_half(st[8]),
		.idle_error_msb(st[7:0]), .tx_base_word(tx_base_word),
		.tx_next_word(tx_next_word), .test_mode(test_mode),
		.ms_manual(ms_manual), .ms_master_value(ms_master_value),
		.port_multi(port_multi), .adv_1000_full(adv_1000_full),
		.adv_1000_half(adv_1000_half));
	link_partner_model i_lp (.clk(clk), .rx_base_valid(rx_base_valid),
		.rx_base_word(rx_base_word), .rx_next_valid(rx_next_valid),
		.rx_next_word(rx_next_word), .partner_an_able(partner_an_able),
		.parallel_fault(parallel_fault), .next_page_sent(next_page_sent),
		.st(st));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic results();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results
	task automatic cmp(input string n, input logic [31:0] e,
		input logic [31:0] s);
		checks++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask : cmp
	// Holds the request until ack is sampled; the wait is bounded
	task automatic bus(input logic wr, input logic [31:0] a,
		input logic [15:0] d, input logic [3:0] s, input logic [15:0] e,
		input logic c);
		int n;
		q.push_back('{c, {16'h0, e}});
		@(posedge clk);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= wr;
		adr_i <= a;
		dat_i <= {rnd() & 32'hffff0000} | d;
		sel_i <= s;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (ack_o !== 1'b1) begin
			errors++;
			results();
		end
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask : bus
	task automatic rd(input logic [31:0] a, input logic [15:0] e);
		bus(1'b0, a, 16'h0, 4'h3, e, 1'b1);
	endtask : rd
	task automatic wr(input logic [31:0] a, input logic [15:0] d,
		input logic [3:0] s);
		bus(1'b1, a, d, s, 16'h0, 1'b0);
	endtask : wr
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask : settle
	// ------------------------------------------------------------
	// Read-data monitor
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (ack_o === 1'b1) begin
			if (q.size() == 0) begin
				errors++;
			end else begin
				x = q.pop_front();
				if (x.chk)
					cmp("dat_o", x.v, dat_o);
			end
		end
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 32'hfc3a;
		{resetn, cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} = 72'h0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		cmp("tx_base_word", 16'h01e1, tx_base_word);
		cmp("tx_next_word", 16'h2001, tx_next_word);
		for (int i = 0; i < 10; i++)
			rd({24'h0, ra[i]}, rv[i]);
		wr(32'h10, 16'hffff, 4'h3);
		rd(32'h10, 16'hbde1);
		settle();
		cmp("tx_base_word", 16'hbde1, tx_base_word);
		wr(32'h10, 16'h0000, 4'h3);
		rd(32'h10, 16'h0001);
		wr(32'h1c, 16'hffff, 4'h3);
		rd(32'h1c, 16'ha7ff);
		settle();
		cmp("tx_next_word", 16'ha7ff, tx_next_word);
		i_lp.ev(1'b0, 1'b1);
		i_lp.status(15'h4000);
		settle();
		cmp("tx_next_word", 16'hbfff, tx_next_word);
		i_lp.status(15'h0);
		for (int c = 0; c < 8; c++) begin
			r = rnd();
			v = {c[2:0], r[12:0]};
			wr(32'h24, v, 4'h3);
			rd(32'h24, v);
			settle();
			cmp("gb_outputs", {(c <= 4) ? c[2:0] : 3'h0, v[12:8]},
				{test_mode, ms_manual, ms_master_value, port_multi,
				adv_1000_full, adv_1000_half});
		end
		wr(32'h24, 16'h0000, 4'h1);
		rd(32'h24, {v[15:8], 8'h00});
		r = rnd();
		w = r[15:0];
		i_lp.base(w, 1'b1);
		rd(32'h14, w);
		rd(32'h18, {12'h0, w[15], 3'h7});
		rd(32'h18, {12'h0, w[15], 3'h5});
		wr(32'h14, 16'hffff, 4'h3);
		wr(32'h3c, 16'h0000, 4'h3);
		rd(32'h14, w);
		rd(32'h3c, 16'h3000);
		i_lp.ev(1'b1, 1'b0);
		rd(32'h18, {11'h1, w[15], 3'h5});
		rd(32'h18, {12'h0, w[15], 3'h5});
		r = rnd();
		i_lp.next(r[15:0]);
		rd(32'h20, {1'b0, r[14:0]});
		repeat (2) begin
			r = rnd();
			i_lp.status({1'b0, r[13:0]});
			settle();
			rd(32'h28, {r[13:8], 2'b00, r[7:0]});
		end
		wr(32'h50, 16'hffff, 4'h3);
		rd(32'h50, 16'h0000);
		rd(32'h10, 16'h0001);
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		rd(32'h10, 16'h01e1);
		rd(32'h24, 16'h0000);
		rd(32'h14, 16'h0000);
		results();
	end
endmodule : phy_autoneg_gigabit_regs_tb_top
